// >>> rtl/vapt_pkg.sv
// Operation
// (RULE1) two banks, four 32-bit indexed registers
// (RULE2) index 1 only with six or more bits
// (RULE3) index 2 and 3 only with seven bits
// (RULE4) unprovided index access gives undefined instruction
// (RULE5) below five bits, high index-0 bits read zero
// (RULE6) bit set while active without priority drop
// (RULE7) five bits: index 0, bit from priority[7:3]
// (RULE8) six bits: priority[7] index, [6:2] bit
// (RULE9) seven bits: priority[7:6] index, [5:1] bit
// (RULE10) software restores group 0 before group 1
// (RULE11) software never sets same priority in both
// (RULE12) lowest implemented priority bit may be omitted
// (RULE13) all bits clear to zero on reset
// (RULE14) hypervisor access traps when sysreg access off
// (RULE15) encoding op0 3, op1 4, CRn 12, CRm 8/9
// (RULE16) only hypervisor and monitor levels reach registers
package vapt_pkg;

	localparam int unsigned NUM_GROUPS        = 2;
	localparam int unsigned NUM_BANKS         = 4;
	localparam int unsigned REG_W             = 32;
	localparam int unsigned PRIO_W            = 8;
	localparam int unsigned PRIO_BITS_DEFAULT = 5;
	localparam int unsigned FLAT_W            = NUM_GROUPS * NUM_BANKS * REG_W;

	localparam logic [1:0]  OP0_SYSREG = 2'h3;
	localparam logic [2:0]  OP1_HYP    = 3'h4;
	localparam logic [3:0]  CRN_VIF    = 4'hC;
	localparam logic [3:0]  CRM_GRP0   = 4'h8;
	localparam logic [3:0]  CRM_GRP1   = 4'h9;
	localparam logic [31:0] AP_RESET   = 32'h0;

	typedef enum logic [1:0] {
		user_level,
		guest_level,
		hypervisor_level,
		secure_monitor_level
	} exc_level_type;

	typedef struct packed {
		logic          valid;
		logic          write;
		exc_level_type level;
		logic [1:0]    op0;
		logic [2:0]    op1;
		logic [3:0]    crn;
		logic [3:0]    crm;
		logic [2:0]    op2;
		logic [31:0]   wdata;
	} sysreg_req_type;

	typedef struct packed {
		logic        done;
		logic        hit;
		logic        undef;
		logic        trap;
		logic [31:0] rdata;
	} sysreg_resp_type;

	typedef struct packed {
		logic       activate;
		logic       drop;
		logic       group;
		logic [7:0] prio;
	} prio_evt_type;

	function automatic logic [2:0] banks_for(input int unsigned bits);
		if (bits >= 7)
			return 3'h4;
		else if (bits == 6)
			return 3'h2;
		else
			return 3'h1;
	endfunction : banks_for

	function automatic logic [1:0] map_index(input logic [7:0] p,
		input int unsigned bits);
		if (bits >= 7)
			return p[7:6];
		else if (bits == 6)
			return {1'b0, p[7]};
		else
			return 2'h0;
	endfunction : map_index

	function automatic logic [4:0] map_bit(input logic [7:0] p,
		input int unsigned bits);
		if (bits >= 7)
			return p[5:1];
		else if (bits == 6)
			return p[6:2];
		else if (bits == 5)
			return p[7:3];
		else
			return 5'(p[7:4] >> (4 - bits));
	endfunction : map_bit

	// implemented bits of one index; lowest priority bit omitted
	function automatic logic [31:0] impl_mask(input int unsigned idx,
		input int unsigned bits);
		logic [31:0] m;
		m = 32'h0;
		if (idx < 32'(banks_for(bits)))
			m = 32'hFFFF_FFFF;
		if (bits < 5 && idx == 0)
			m = (32'h1 << ((32'h1 << bits) - 1)) - 32'h1;
		else if (idx == 32'(banks_for(bits)) - 1)
			m[31] = 1'b0;
		return m;
	endfunction : impl_mask

endpackage : vapt_pkg

// >>> rtl/virtual_active_priority_tracker.sv
`timescale 1ns/100ps
module virtual_active_priority_tracker #(
	parameter int unsigned PRIO_BITS = vapt_pkg::PRIO_BITS_DEFAULT
) (
	input  wire logic                      core_clk,
	input  wire logic                      rst,
	input  wire vapt_pkg::sysreg_req_type  req,
	input  wire logic                      hyp_sysreg_access_enable,
	input  wire vapt_pkg::prio_evt_type    evt,
	output      vapt_pkg::sysreg_resp_type resp
);
	import vapt_pkg::*;

	logic [31:0]     ap_r   [NUM_GROUPS][NUM_BANKS];
	logic [31:0]     ap_nxt [NUM_GROUPS][NUM_BANKS];
	sysreg_resp_type resp_r;
	sysreg_resp_type resp_nxt;

	logic            enc_hit;
	logic            req_grp;
	logic [1:0]      req_idx;
	logic            level_ok;
	logic            trap_c;
	logic            idx_ok;
	logic            do_write;
	logic [1:0]      evt_idx;
	logic [4:0]      evt_bit;
	logic            drop_found;
	logic [6:0]      drop_pos;
	logic [FLAT_W-1:0] ap_flat;
	logic [FLAT_W-1:0] mask_flat;

	// decode of the system-register encoding
	assign enc_hit = req.valid && req.op0 == OP0_SYSREG &&
		req.op1 == OP1_HYP && req.crn == CRN_VIF &&
		(req.crm == CRM_GRP0 || req.crm == CRM_GRP1) &&
		req.op2[2] == 1'b0; // RULE15
	assign req_grp = (req.crm == CRM_GRP1); // RULE15
	assign req_idx = req.op2[1:0]; // RULE15

	// guest and user levels never reach the banks
	assign level_ok = req.level == hypervisor_level ||
		req.level == secure_monitor_level; // RULE16
	assign trap_c = req.level == hypervisor_level &&
		!hyp_sysreg_access_enable; // RULE14
	assign idx_ok = {1'b0, req_idx} < banks_for(PRIO_BITS); // RULE2 RULE3
	assign do_write = enc_hit && req.write && level_ok && !trap_c &&
		idx_ok;

	// priority to index and bit position
	assign evt_idx = map_index(evt.prio, PRIO_BITS); // RULE7 RULE8 RULE9
	assign evt_bit = map_bit(evt.prio, PRIO_BITS); // RULE7 RULE8 RULE9

	// priority drop: highest active priority across both groups
	always_comb begin
		drop_found = 1'b0;
		drop_pos   = 7'h0;
		for (int i = NUM_BANKS * REG_W - 1; i >= 0; i--) begin
			if (ap_r[0][i / REG_W][i % REG_W] ||
				ap_r[1][i / REG_W][i % REG_W]) begin
				drop_found = 1'b1;
				drop_pos   = 7'(i);
			end
		end
	end

	// next state: write, then drop, then activation wins
	always_comb begin
		ap_nxt = ap_r;
		if (do_write)
			ap_nxt[req_grp][req_idx] = req.wdata; // RULE1
		if (evt.drop && drop_found) begin
			ap_nxt[0][drop_pos[6:5]][drop_pos[4:0]] = 1'b0; // RULE6
			ap_nxt[1][drop_pos[6:5]][drop_pos[4:0]] = 1'b0; // RULE6
		end
		if (evt.activate)
			ap_nxt[evt.group][evt_idx][evt_bit] = 1'b1; // RULE6
		for (int g = 0; g < NUM_GROUPS; g++) begin
			for (int b = 0; b < NUM_BANKS; b++) begin
				// unprovided bits read zero, ignore writes
				ap_nxt[g][b] = ap_nxt[g][b] &
					impl_mask(b, PRIO_BITS); // RULE5 RULE12
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int g = 0; g < NUM_GROUPS; g++) begin
				for (int b = 0; b < NUM_BANKS; b++) begin
					ap_r[g][b] <= AP_RESET; // RULE13
				end
			end
		end else begin
			ap_r <= ap_nxt;
		end
	end

	// answer: trap before unprovided-index exception
	always_comb begin
		resp_nxt       = '0;
		resp_nxt.done  = req.valid;
		resp_nxt.hit   = enc_hit;
		if (enc_hit) begin
			if (!level_ok)
				resp_nxt.undef = 1'b1; // RULE16
			else if (trap_c)
				resp_nxt.trap = 1'b1; // RULE14
			else if (!idx_ok)
				resp_nxt.undef = 1'b1; // RULE4
			else if (!req.write)
				resp_nxt.rdata = ap_r[req_grp][req_idx]; // RULE1
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			resp_r <= '0;
		else
			resp_r <= resp_nxt;
	end

	assign resp = resp_r;

	// flattened view for checking
	generate
		for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_flat
			for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
				assign ap_flat[(g*NUM_BANKS+b)*REG_W +: REG_W] =
					ap_r[g][b];
				assign mask_flat[(g*NUM_BANKS+b)*REG_W +: REG_W] =
					impl_mask(b, PRIO_BITS);
			end
		end
	endgenerate

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	property p_reset_clear;
		$fell(rst) |-> ap_flat == '0;
	endproperty
	a_reset_clear: assert property (p_reset_clear) // RULE13
		else $error("banks not clear after reset");

	property p_unimpl_zero;
		(ap_flat & ~mask_flat) == '0;
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) // RULE5
		else $error("unprovided active bit is set");

	property p_bad_index_undef;
		enc_hit && level_ok && !trap_c && !idx_ok
			|=> resp.undef && !resp.trap && resp.rdata == '0;
	endproperty
	a_bad_index_undef: assert property (p_bad_index_undef) // RULE4
		else $error("unprovided index not undefined");

	property p_sre_trap;
		enc_hit && req.level == hypervisor_level &&
			!hyp_sysreg_access_enable
			|=> resp.trap && !resp.undef ##1 1'b1;
	endproperty
	a_sre_trap: assert property (p_sre_trap) // RULE14
		else $error("hypervisor access did not trap");

	property p_low_level_blocked;
		enc_hit && !level_ok && !evt.activate && !evt.drop
			|=> resp.undef && ap_flat == $past(ap_flat);
	endproperty
	a_low_level_blocked: assert property (p_low_level_blocked) // RULE16
		else $error("low level access reached the banks");

	property p_activate_sets;
		evt.activate |=>
			(ap_r[$past(evt.group)][$past(evt_idx)][$past(evt_bit)] ||
			!mask_flat[($past(evt.group) * NUM_BANKS + $past(evt_idx)) *
			REG_W + $past(evt_bit)]);
	endproperty
	a_activate_sets: assert property (p_activate_sets) // RULE6
		else $error("activation did not set its bit");

	property p_read_returns;
		enc_hit && !req.write && level_ok && !trap_c && idx_ok
			|=> resp.done && resp.hit && !resp.undef &&
			resp.rdata == $past(ap_r[req_grp][req_idx]);
	endproperty
	a_read_returns: assert property (p_read_returns) // RULE1
		else $error("read data does not match bank");

	property p_drop_clears;
		evt.drop && drop_found && !evt.activate && !do_write
			|=> $countones(ap_flat) < $countones($past(ap_flat));
	endproperty
	a_drop_clears: assert property (p_drop_clears) // RULE6
		else $error("priority drop cleared nothing");

	property p_map_position;
		evt.activate && evt.prio == 8'h00 |=> ap_r[$past(evt.group)][0][0];
	endproperty
	a_map_position: assert property (p_map_position) // RULE7 RULE8 RULE9
		else $error("top priority not at index 0 bit 0");

	cover property (enc_hit && req.write && do_write);
	cover property (enc_hit && !idx_ok && level_ok && !trap_c);
	cover property (evt.activate ##1 evt.drop);
	property p_done_follows;
		req.valid |=> resp.done;
	endproperty
	a_done_follows: assert property (p_done_follows) // RULE1
		else $error("request got no answer");

	property p_idle_quiet;
		!req.valid |=> !resp.done && !resp.hit && resp.rdata == '0;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) // RULE1
		else $error("answer without request");

	property p_miss_quiet;
		req.valid && !enc_hit |=> !resp.hit && !resp.undef &&
			!resp.trap && resp.rdata == '0;
	endproperty
	a_miss_quiet: assert property (p_miss_quiet) // RULE15
		else $error("foreign encoding was answered");

	property p_write_lands;
		do_write && !evt.activate && !evt.drop |=>
			ap_r[$past(req_grp)][$past(req_idx)] == ($past(req.wdata) &
			mask_flat[($past(req_grp) * NUM_BANKS + $past(req_idx)) *
			REG_W +: REG_W]);
	endproperty
	a_write_lands: assert property (p_write_lands) // RULE1
		else $error("write did not land");

	property p_trap_no_write;
		enc_hit && trap_c && !evt.activate && !evt.drop
			|=> ap_flat == $past(ap_flat);
	endproperty
	a_trap_no_write: assert property (p_trap_no_write) // RULE14
		else $error("trapped access changed a bank");

	property p_undef_no_write;
		enc_hit && level_ok && !trap_c && !idx_ok && !evt.activate &&
			!evt.drop |=> ap_flat == $past(ap_flat);
	endproperty
	a_undef_no_write: assert property (p_undef_no_write) // RULE4
		else $error("unprovided index changed a bank");

	property p_idle_hold;
		!req.valid && !evt.activate && !evt.drop
			|=> ap_flat == $past(ap_flat);
	endproperty
	a_idle_hold: assert property (p_idle_hold) // RULE6
		else $error("banks changed with no cause");

	property p_monitor_no_trap;
		enc_hit && req.level == secure_monitor_level |=> !resp.trap;
	endproperty
	a_monitor_no_trap: assert property (p_monitor_no_trap) // RULE14
		else $error("monitor level access trapped");

	cover property (enc_hit && trap_c);
	cover property (evt.activate && evt.prio == 8'h00);

endmodule : virtual_active_priority_tracker

// >>> testbench/test_virtual_active_priority_tracker.sv
`timescale 1ns/100ps
module test_virtual_active_priority_tracker;
	import vapt_pkg::*;
	logic            core_clk = 1'b0;
	logic            rst = 1'b1;
	sysreg_req_type  req = '0;
	logic            hyp_sysreg_access_enable = 1'b1;
	prio_evt_type    evt = '0;
	sysreg_resp_type resp;
	sysreg_resp_type r;
	int              miscompares = 0;
	int              checks = 0;

	always #4 core_clk = ~core_clk;

	virtual_active_priority_tracker #(
		.PRIO_BITS(6)
	) u_virtual_active_priority_tracker (
		.core_clk                (core_clk),
		.rst                     (rst),
		.req                     (req),
		.hyp_sysreg_access_enable(hyp_sysreg_access_enable),
		.evt                     (evt),
		.resp                    (resp)
	);

	task automatic close_out;
		if (miscompares == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t word %h want %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t flags %h want %h", $time, got, exp);
		end
	endtask : chk_flags

	// one request, driven and released on falling edges
	task automatic acc(input exc_level_type lvl, input logic wr,
		input logic [3:0] crm, input logic [2:0] op2,
		input logic [31:0] wd, input logic [3:0] crn = CRN_VIF);
		req = '{1'b1, wr, lvl, OP0_SYSREG, OP1_HYP, crn, crm, op2, wd};
		@(posedge core_clk);
		@(negedge core_clk);
		r = resp;
		req = '0;
		@(negedge core_clk);
	endtask : acc

	// flags order: done, hit, undef, trap
	task automatic rd(input logic [3:0] crm, input logic [2:0] op2,
		input logic [31:0] exp);
		acc(hypervisor_level, 1'b0, crm, op2, 32'h0);
		chk_flags({r.done, r.hit, r.undef, r.trap}, 4'hC);
		chk_word(r.rdata, exp);
	endtask : rd

	task automatic fire(input logic act, input logic grp, input logic [7:0] p);
		evt = '{act, ~act, grp, p};
		@(negedge core_clk);
		evt = '0;
		@(negedge core_clk);
	endtask : fire

	task automatic t_reset;
		for (int i = 0; i < 2; i++) begin
			rd(CRM_GRP0, 3'(i), 32'h0);
			rd(CRM_GRP1, 3'(i), 32'h0);
		end
	endtask : t_reset

	task automatic t_rw;
		acc(hypervisor_level, 1'b1, CRM_GRP0, 3'h0, 32'hFFFF_FFFF);
		rd(CRM_GRP0, 3'h0, 32'hFFFF_FFFF);
		acc(secure_monitor_level, 1'b1, CRM_GRP1, 3'h1, 32'hFFFF_FFFF);
		rd(CRM_GRP1, 3'h1, 32'h7FFF_FFFF);
		rd(CRM_GRP0, 3'h1, 32'h0);
		acc(hypervisor_level, 1'b1, CRM_GRP0, 3'h0, 32'h0);
		acc(hypervisor_level, 1'b1, CRM_GRP1, 3'h1, 32'h0);
		rd(CRM_GRP0, 3'h0, 32'h0);
	endtask : t_rw

	task automatic t_refuse;
		acc(hypervisor_level, 1'b1, CRM_GRP0, 3'h2, 32'hF);
		chk_flags({r.done, r.hit, r.undef, r.trap}, 4'hE);
		acc(hypervisor_level, 1'b0, CRM_GRP1, 3'h3, 32'h0);
		chk_flags({r.done, r.hit, r.undef, r.trap}, 4'hE);
		acc(user_level, 1'b1, CRM_GRP0, 3'h0, 32'hF);
		chk_flags({r.done, r.hit, r.undef, r.trap}, 4'hE);
		acc(guest_level, 1'b0, CRM_GRP1, 3'h0, 32'h0);
		chk_flags({r.done, r.hit, r.undef, r.trap}, 4'hE);
		acc(hypervisor_level, 1'b1, CRM_GRP0, 3'h0, 32'hF, 4'hB);
		chk_flags({r.done, r.hit, r.undef, r.trap}, 4'h8);
		hyp_sysreg_access_enable = 1'b0;
		acc(hypervisor_level, 1'b1, CRM_GRP0, 3'h0, 32'hF);
		chk_flags({r.done, r.hit, r.undef, r.trap}, 4'hD);
		acc(secure_monitor_level, 1'b0, CRM_GRP0, 3'h0, 32'h0);
		chk_flags({r.done, r.hit, r.undef, r.trap}, 4'hC);
		hyp_sysreg_access_enable = 1'b1;
		rd(CRM_GRP0, 3'h0, 32'h0);
	endtask : t_refuse

	task automatic t_evt;
		fire(1'b1, 1'b1, 8'h84);
		fire(1'b1, 1'b0, 8'h08);
		rd(CRM_GRP1, 3'h1, 32'h2);
		rd(CRM_GRP0, 3'h0, 32'h4);
		fire(1'b0, 1'b0, 8'h00);
		rd(CRM_GRP0, 3'h0, 32'h0);
		rd(CRM_GRP1, 3'h1, 32'h2);
		fire(1'b0, 1'b0, 8'h00);
		rd(CRM_GRP1, 3'h1, 32'h0);
		fire(1'b1, 1'b0, 8'h00);
		rd(CRM_GRP0, 3'h0, 32'h1);
		fire(1'b0, 1'b0, 8'h00);
		rd(CRM_GRP0, 3'h0, 32'h0);
	endtask : t_evt

	initial begin
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		t_reset();
		t_rw();
		t_refuse();
		t_evt();
		close_out();
	end

	initial begin
		#20000;
		miscompares++;
		close_out();
	end
endmodule : test_virtual_active_priority_tracker
